// >>> rtl/uisl_pkg.sv
// package for the interrupt identification and line format block
// holds register offsets, field positions, reset values and carrier types
// assumes a single clock domain and a plain strobe-based register port
package uisl_pkg;

    // ==========================================================
    // register port
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] OFS_INT_IDENT = 3'h0;
    localparam logic [ADDR_W-1:0] OFS_LINE_FMT = 3'h1;
    localparam logic [ADDR_W-1:0] OFS_EVT_STATUS = 3'h2;
    localparam logic [ADDR_W-1:0] OFS_EVT_CLEAR = 3'h3;
    localparam logic [ADDR_W-1:0] OFS_EVT_ENABLE = 3'h4;
    localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;

    // ==========================================================
    // line_format_control fields
    localparam int LFC_DIV_LATCH = 7;
    localparam int LFC_BREAK = 6;
    localparam int LFC_PAR_HI = 5;
    localparam int LFC_PAR_LO = 3;
    localparam int LFC_STOP = 2;
    localparam int LFC_WLEN_HI = 1;
    localparam int LFC_WLEN_LO = 0;
    localparam logic [DATA_W-1:0] LFC_RESET = 8'h00;

    // parity selection patterns on bits 5:3
    localparam logic [2:0] PAR_ODD = 3'h1;
    localparam logic [2:0] PAR_EVEN = 3'h3;
    localparam logic [2:0] PAR_FORCE_ONE = 3'h5;
    localparam logic [2:0] PAR_FORCE_ZERO = 3'h7;

    // word length codes and resulting data bits
    localparam logic [1:0] WLEN_5 = 2'h0;
    localparam logic [3:0] DATA_BITS_BASE = 4'h5;

    // stop length in half bit times
    localparam logic [2:0] STOP_ONE = 3'h2;
    localparam logic [2:0] STOP_ONE_HALF = 3'h3;
    localparam logic [2:0] STOP_TWO = 3'h4;

    // ==========================================================
    // interrupt_identification fields and codes (bits 3:0)
    localparam logic [3:0] CODE_NONE = 4'h1;
    localparam logic [3:0] CODE_LINE = 4'h6;
    localparam logic [3:0] CODE_RXDATA = 4'h4;
    localparam logic [3:0] CODE_TIMEOUT = 4'hC;
    localparam logic [3:0] CODE_TXEMPTY = 4'h2;
    localparam logic [3:0] CODE_MODEM = 4'h0;
    localparam logic [1:0] FIFO_FLAG_ON = 2'h3;
    localparam logic [1:0] FIFO_FLAG_OFF = 2'h0;
    localparam logic [1:0] UNUSED_BITS = 2'h0;

    // ==========================================================
    // event register layout
    localparam int NUM_SRC = 5;
    localparam logic [NUM_SRC-1:0] EVT_RESET = 5'h00;

    // ==========================================================
    // carrier types
    typedef enum logic [2:0] {
        SRC_NONE,
        SRC_LINE,
        SRC_RXDATA,
        SRC_TIMEOUT,
        SRC_TXEMPTY,
        SRC_MODEM
    } uisl_src_type;

    typedef enum logic [2:0] {
        PARITY_NONE,
        PARITY_ODD,
        PARITY_EVEN,
        PARITY_FORCE_ONE,
        PARITY_FORCE_ZERO
    } uisl_parity_type;

    // source conditions, already gated by the enable logic outside
    typedef struct packed {
        logic modem;
        logic tx_empty;
        logic rx_timeout;
        logic rx_data;
        logic line_status;
    } uisl_cond_type;

    typedef struct packed {
        logic [3:0] data_bits;
        logic [2:0] stop_halves;
        uisl_parity_type parity;
    } uisl_fmt_type;

endpackage

// >>> rtl/uisl_top.sv
// interrupt identification and character format control for one channel
// assumes source conditions arrive as levels synchronous to CLK and that the
// transmitter shifter, fifos and baud generator sit outside this block
`timescale 1ns/1ps

module uisl_top (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic [uisl_pkg::ADDR_W-1:0] ADDR,
    input wire logic [uisl_pkg::DATA_W-1:0] WDATA,
    input wire logic WR_STB,
    input wire logic RD_STB,
    output logic [uisl_pkg::DATA_W-1:0] RDATA,
    input wire uisl_pkg::uisl_cond_type SRC_COND,
    input wire logic FIFO_ENABLED,
    input wire logic TX_SHIFT_DATA,
    output logic SERIAL_OUT_PIN,
    output logic DIVISOR_LATCH_EN,
    output uisl_pkg::uisl_fmt_type LINE_FORMAT,
    output logic IRQ
);

    // ==========================================================
    // functions

    // identification code for a source; used for the read path
    function automatic logic [3:0] src_code(input uisl_pkg::uisl_src_type s);
        logic [3:0] c;
        c = uisl_pkg::CODE_NONE;
        unique case (s)
            uisl_pkg::SRC_NONE: c = uisl_pkg::CODE_NONE;
            uisl_pkg::SRC_LINE: c = uisl_pkg::CODE_LINE;
            uisl_pkg::SRC_RXDATA: c = uisl_pkg::CODE_RXDATA;
            uisl_pkg::SRC_TIMEOUT: c = uisl_pkg::CODE_TIMEOUT;
            uisl_pkg::SRC_TXEMPTY: c = uisl_pkg::CODE_TXEMPTY;
            uisl_pkg::SRC_MODEM: c = uisl_pkg::CODE_MODEM;
            default: c = uisl_pkg::CODE_NONE;
        endcase
        return c;
    endfunction

    // whether the condition behind a source is still raised
    function automatic logic src_active(
        input uisl_pkg::uisl_src_type s,
        input uisl_pkg::uisl_cond_type c
    );
        logic a;
        a = 1'b0;
        unique case (s)
            uisl_pkg::SRC_NONE: a = 1'b0;
            uisl_pkg::SRC_LINE: a = c.line_status;
            uisl_pkg::SRC_RXDATA: a = c.rx_data;
            uisl_pkg::SRC_TIMEOUT: a = c.rx_timeout;
            uisl_pkg::SRC_TXEMPTY: a = c.tx_empty;
            uisl_pkg::SRC_MODEM: a = c.modem;
            default: a = 1'b0;
        endcase
        return a;
    endfunction

    // ==========================================================
    // state

    logic [uisl_pkg::DATA_W-1:0] lfc_r;
    logic [uisl_pkg::DATA_W-1:0] lfc_nxt;
    uisl_pkg::uisl_src_type cur_r;
    uisl_pkg::uisl_src_type cur_nxt;
    uisl_pkg::uisl_src_type top_src;
    logic [uisl_pkg::NUM_SRC-1:0] cond_vec;
    logic [uisl_pkg::NUM_SRC-1:0] cond_prev_r;
    logic [uisl_pkg::NUM_SRC-1:0] evt_stat_r;
    logic [uisl_pkg::NUM_SRC-1:0] evt_stat_nxt;
    logic [uisl_pkg::NUM_SRC-1:0] evt_en_r;
    logic [uisl_pkg::NUM_SRC-1:0] evt_en_nxt;
    logic [uisl_pkg::DATA_W-1:0] rdata_r;
    logic [uisl_pkg::DATA_W-1:0] rdata_nxt;
    logic irq_r;
    logic irq_nxt;
    logic serial_r;
    logic serial_nxt;
    uisl_pkg::uisl_fmt_type fmt_r;
    uisl_pkg::uisl_fmt_type fmt_nxt;

    // ==========================================================
    // register decode

    wire sel_ident = (ADDR == uisl_pkg::OFS_INT_IDENT);
    wire sel_lfc = (ADDR == uisl_pkg::OFS_LINE_FMT);
    wire sel_stat = (ADDR == uisl_pkg::OFS_EVT_STATUS);
    wire sel_clr = (ADDR == uisl_pkg::OFS_EVT_CLEAR);
    wire sel_en = (ADDR == uisl_pkg::OFS_EVT_ENABLE);
    wire wr_lfc = WR_STB && sel_lfc;
    wire wr_clr = WR_STB && sel_clr;
    wire wr_en = WR_STB && sel_en;

    assign lfc_nxt = wr_lfc ? WDATA : lfc_r;
    assign evt_en_nxt = wr_en ? WDATA[uisl_pkg::NUM_SRC-1:0] : evt_en_r;

    // ==========================================================
    // priority arbitration
    // within level 2 the time-out is taken first, since it means the
    // receiver went idle with data left behind

    assign top_src = SRC_COND.line_status ? uisl_pkg::SRC_LINE :
                     SRC_COND.rx_timeout ? uisl_pkg::SRC_TIMEOUT :
                     SRC_COND.rx_data ? uisl_pkg::SRC_RXDATA :
                     SRC_COND.tx_empty ? uisl_pkg::SRC_TXEMPTY :
                     SRC_COND.modem ? uisl_pkg::SRC_MODEM :
                     uisl_pkg::SRC_NONE;

    // a reported source stays until its condition is serviced, even if a
    // higher one shows up meanwhile; then the next highest is taken
    assign cur_nxt = src_active(cur_r, SRC_COND) ? cur_r : top_src;

    // ==========================================================
    // identification read value

    wire [1:0] fifo_flags = FIFO_ENABLED ? uisl_pkg::FIFO_FLAG_ON
                                         : uisl_pkg::FIFO_FLAG_OFF;
    wire [uisl_pkg::DATA_W-1:0] ident_val = {fifo_flags, uisl_pkg::UNUSED_BITS,
                                             src_code(cur_r)};

    // ==========================================================
    // event capture: a rising condition sets a sticky bit

    assign cond_vec = SRC_COND;

    genvar gi;
    generate
        for (gi = 0; gi < uisl_pkg::NUM_SRC; gi++)
        begin : g_evt
            wire rise = cond_vec[gi] && !cond_prev_r[gi];
            wire clr = wr_clr && WDATA[gi];
            // set wins when a clear lands in the same cycle
            assign evt_stat_nxt[gi] = rise ? 1'b1 : (clr ? 1'b0 : evt_stat_r[gi]);
        end
    endgenerate

    assign irq_nxt = |(evt_stat_nxt & evt_en_nxt);

    // ==========================================================
    // read path: data valid only in the cycle after the strobe

    wire [uisl_pkg::DATA_W-1:0] stat_val = {{(uisl_pkg::DATA_W-uisl_pkg::NUM_SRC){1'b0}},
                                            evt_stat_r};
    wire [uisl_pkg::DATA_W-1:0] en_val = {{(uisl_pkg::DATA_W-uisl_pkg::NUM_SRC){1'b0}},
                                          evt_en_r};
    wire [uisl_pkg::DATA_W-1:0] read_mux = sel_ident ? ident_val :
                                           sel_lfc ? lfc_r :
                                           sel_stat ? stat_val :
                                           sel_en ? en_val :
                                           uisl_pkg::READ_ZERO;

    assign rdata_nxt = RD_STB ? read_mux : uisl_pkg::READ_ZERO;

    // ==========================================================
    // character format decode

    wire [2:0] par_sel = lfc_r[uisl_pkg::LFC_PAR_HI:uisl_pkg::LFC_PAR_LO];
    wire [1:0] wlen = lfc_r[uisl_pkg::LFC_WLEN_HI:uisl_pkg::LFC_WLEN_LO];
    wire par_on = lfc_r[uisl_pkg::LFC_PAR_LO];

    uisl_pkg::uisl_parity_type par_mode;
    assign par_mode = !par_on ? uisl_pkg::PARITY_NONE :
                      (par_sel == uisl_pkg::PAR_EVEN) ? uisl_pkg::PARITY_EVEN :
                      (par_sel == uisl_pkg::PAR_FORCE_ZERO) ? uisl_pkg::PARITY_FORCE_ZERO :
                      (par_sel == uisl_pkg::PAR_ODD) ? uisl_pkg::PARITY_ODD :
                      uisl_pkg::PARITY_FORCE_ONE;

    wire [2:0] stop_len = !lfc_r[uisl_pkg::LFC_STOP] ? uisl_pkg::STOP_ONE :
                          (wlen == uisl_pkg::WLEN_5) ? uisl_pkg::STOP_ONE_HALF :
                          uisl_pkg::STOP_TWO;

    assign fmt_nxt.data_bits = uisl_pkg::DATA_BITS_BASE + {2'b00, wlen};
    assign fmt_nxt.stop_halves = stop_len;
    assign fmt_nxt.parity = par_mode;

    // break holds the line low; otherwise the shifter drives it
    assign serial_nxt = lfc_nxt[uisl_pkg::LFC_BREAK] ? 1'b0 : TX_SHIFT_DATA;

    // ==========================================================
    // flip-flops

    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            lfc_r <= uisl_pkg::LFC_RESET;
            cur_r <= uisl_pkg::SRC_NONE;
        end
        else
        begin
            lfc_r <= lfc_nxt;
            cur_r <= cur_nxt;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            cond_prev_r <= uisl_pkg::EVT_RESET;
            evt_stat_r <= uisl_pkg::EVT_RESET;
            evt_en_r <= uisl_pkg::EVT_RESET;
            irq_r <= 1'b0;
        end
        else
        begin
            cond_prev_r <= cond_vec;
            evt_stat_r <= evt_stat_nxt;
            evt_en_r <= evt_en_nxt;
            irq_r <= irq_nxt;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            rdata_r <= uisl_pkg::READ_ZERO;
            serial_r <= 1'b1;
            fmt_r <= '{data_bits: uisl_pkg::DATA_BITS_BASE,
                       stop_halves: uisl_pkg::STOP_ONE,
                       parity: uisl_pkg::PARITY_NONE};
        end
        else
        begin
            rdata_r <= rdata_nxt;
            serial_r <= serial_nxt;
            fmt_r <= fmt_nxt;
        end
    end

    // ==========================================================
    // outputs

    assign RDATA = rdata_r;
    assign SERIAL_OUT_PIN = serial_r;
    assign DIVISOR_LATCH_EN = lfc_r[uisl_pkg::LFC_DIV_LATCH];
    assign LINE_FORMAT = fmt_r;
    assign IRQ = irq_r;

endmodule // uisl_top

// >>> test/uisl_properties.sv
// port checker for uisl_top, attached by bind
// assumes one clock CLK and synchronous active-low RST_B
`timescale 1ns/1ps
module uisl_checker (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic [uisl_pkg::ADDR_W-1:0] ADDR,
    input wire logic [uisl_pkg::DATA_W-1:0] WDATA,
    input wire logic WR_STB,
    input wire logic RD_STB,
    input wire logic [uisl_pkg::DATA_W-1:0] RDATA,
    input wire uisl_pkg::uisl_cond_type SRC_COND,
    input wire logic FIFO_ENABLED,
    input wire logic TX_SHIFT_DATA,
    input wire logic SERIAL_OUT_PIN,
    input wire logic DIVISOR_LATCH_EN,
    input wire uisl_pkg::uisl_fmt_type LINE_FORMAT,
    input wire logic IRQ
);
    // ==========================================================
    // shadow of the break bit, needed because it is not a port
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    logic brk_r;
    wire [4:0] cond = SRC_COND;
    wire fmt_wr = WR_STB && ADDR == uisl_pkg::OFS_LINE_FMT;
    wire id_rd = RD_STB && ADDR == uisl_pkg::OFS_INT_IDENT;
    wire brk_nxt = fmt_wr ? WDATA[6] : brk_r;
    always_ff @(posedge CLK)
    begin
        brk_r <= RST_B && brk_nxt;
    end
    function automatic logic [2:0] par_of(input logic [2:0] p);
        return !p[0] ? 3'h0 : p[2:1] == 2'h0 ? 3'h1 : p[2:1] == 2'h1 ? 3'h2
            : p[2:1] == 2'h2 ? 3'h3 : 3'h4;
    endfunction
    // ==========================================================
    // properties
    property p_rdata_idle;
        !$past(RD_STB) |-> RDATA == uisl_pkg::READ_ZERO;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
    property p_ident_top;
        id_rd |=> RDATA[7:4] == ($past(FIFO_ENABLED) ? 4'hC : 4'h0);
    endproperty
    a_ident_top: assert property (p_ident_top) else $error("ident upper bits wrong");
    property p_ident_none;
        id_rd && $past(cond) == 5'h00 |=> RDATA[3:0] == uisl_pkg::CODE_NONE;
    endproperty
    a_ident_none: assert property (p_ident_none) else $error("idle ident code wrong");
    property p_dle_set;
        fmt_wr |=> DIVISOR_LATCH_EN == $past(WDATA[7]);
    endproperty
    a_dle_set: assert property (p_dle_set) else $error("latch enable not taken");
    property p_dle_hold;
        !fmt_wr |=> $stable(DIVISOR_LATCH_EN);
    endproperty
    a_dle_hold: assert property (p_dle_hold) else $error("latch enable moved");
    property p_break;
        $past(RST_B) |-> SERIAL_OUT_PIN == ($past(brk_nxt) ? 1'b0 : $past(TX_SHIFT_DATA));
    endproperty
    a_break: assert property (p_break) else $error("serial output wrong");
    property p_parity;
        fmt_wr |-> ##2 LINE_FORMAT.parity == par_of($past(WDATA[5:3], 2));
    endproperty
    a_parity: assert property (p_parity) else $error("parity selection wrong");
    property p_stop;
        fmt_wr |-> ##2 LINE_FORMAT.stop_halves == (!$past(WDATA[2], 2) ? 3'h2
            : $past(WDATA[1:0], 2) == 2'h0 ? 3'h3 : 3'h4);
    endproperty
    a_stop: assert property (p_stop) else $error("stop length wrong");
    property p_wlen;
        fmt_wr |-> ##2 LINE_FORMAT.data_bits == 4'h5 + $past(WDATA[1:0], 2);
    endproperty
    a_wlen: assert property (p_wlen) else $error("word length wrong");
endmodule // uisl_checker

bind uisl_top uisl_checker chk (.CLK, .RST_B, .ADDR, .WDATA, .WR_STB, .RD_STB, .RDATA,
    .SRC_COND, .FIFO_ENABLED, .TX_SHIFT_DATA, .SERIAL_OUT_PIN, .DIVISOR_LATCH_EN,
    .LINE_FORMAT, .IRQ);

// >>> test/uisl_line_model.sv
// far side: transmit shifter stand-in and remote line watcher
// assumes the line is sampled on the block clock
`timescale 1ns/1ps
module uisl_line_model (
    input wire logic clk,
    input wire logic line,
    output logic tx_data,
    output int low_run
);
    // ==========================================================
    // toggling data so a stuck line cannot pass for a copy
    initial tx_data = 1'b1;
    initial low_run = 0;
    always @(posedge clk)
    begin
        tx_data <= ~tx_data;
        low_run <= line ? 0 : low_run + 1;
    end
endmodule // uisl_line_model

// >>> test/testbench.sv
// self-checking bench for uisl_top
// assumes the checker is bound and the line model stands on the serial side
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic [7:0] rdata;
    uisl_pkg::uisl_cond_type cond = '0;
    logic fifo_en = 1'b0;
    logic tx_data, serial_out, dle, irq;
    uisl_pkg::uisl_fmt_type fmt;
    int low_run;
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    uisl_top dut (.CLK(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR_STB(wr_stb),
        .RD_STB(rd_stb), .RDATA(rdata), .SRC_COND(cond), .FIFO_ENABLED(fifo_en),
        .TX_SHIFT_DATA(tx_data), .SERIAL_OUT_PIN(serial_out), .DIVISOR_LATCH_EN(dle),
        .LINE_FORMAT(fmt), .IRQ(irq));
    uisl_line_model far (.clk(clk), .line(serial_out), .tx_data(tx_data), .low_run(low_run));
    initial forever #20 clk = ~clk;
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 2000)
        begin
            err_count++;
            conclude();
        end
    end
    // ==========================================================
    // bus and compare tasks
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chkb(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
        #1;
    endtask
    task automatic rchk(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1 chk({2'b00, rdata}, {2'b00, e});
    endtask
    task automatic setc(input logic [4:0] c, input logic f);
        @(posedge clk);
        cond <= c;
        fifo_en <= f;
    endtask
    function automatic logic [9:0] exp_fmt(input logic [7:0] v);
        logic [2:0] p;
        logic [2:0] s;
        p = !v[3] ? 3'h0 : v[5:4] == 2'h0 ? 3'h1 : v[5:4] == 2'h1 ? 3'h2
            : v[5:4] == 2'h2 ? 3'h3 : 3'h4;
        s = !v[2] ? 3'h2 : v[1:0] == 2'h0 ? 3'h3 : 3'h4;
        return {4'h5 + v[1:0], s, p};
    endfunction
    // ==========================================================
    // scenarios
    task automatic t_reset();
        #1 chk(fmt, {4'h5, 3'h2, 3'h0});
        chk({7'h00, dle, serial_out, irq}, 10'h002);
        rchk(uisl_pkg::OFS_INT_IDENT, 8'h01);
        rchk(uisl_pkg::OFS_LINE_FMT, 8'h00);
    endtask
    task automatic t_codes();
        logic [3:0] code [5] = '{4'h6, 4'h4, 4'hC, 4'h2, 4'h0};
        logic [7:0] e;
        for (int i = 0; i < 5; i++)
        begin
            setc(5'h01 << i, i[0]);
            e = {i[0] ? 4'hC : 4'h0, code[i]};
            rchk(uisl_pkg::OFS_INT_IDENT, e);
            setc(5'h00, 1'b0);
        end
    endtask
    task automatic t_priority();
        // line returns while rx data is still reported: it must wait its turn
        logic [4:0] cs [8] = '{5'h1F, 5'h1E, 5'h1A, 5'h1B, 5'h19, 5'h18, 5'h10, 5'h00};
        logic [7:0] es [8] = '{8'h06, 8'h0C, 8'h04, 8'h04, 8'h06, 8'h02, 8'h00, 8'h01};
        for (int i = 0; i < 8; i++)
        begin
            setc(cs[i], 1'b0);
            rchk(uisl_pkg::OFS_INT_IDENT, es[i]);
        end
    endtask
    task automatic t_format();
        logic [7:0] v [6] = '{8'h08, 8'h1D, 8'h2E, 8'h3B, 8'hC7, 8'h24};
        for (int i = 0; i < 6; i++)
        begin
            wr(uisl_pkg::OFS_LINE_FMT, v[i]);
            rchk(uisl_pkg::OFS_LINE_FMT, v[i]);
            chk(fmt, exp_fmt(v[i]));
            chkb(dle, v[i][7]);
        end
    endtask
    task automatic t_break();
        logic t;
        wr(uisl_pkg::OFS_LINE_FMT, 8'h40);
        repeat (7) @(posedge clk);
        #1 chkb(low_run > 5, 1'b1);
        wr(uisl_pkg::OFS_LINE_FMT, 8'h00);
        repeat (4)
        begin
            t = tx_data;
            @(posedge clk);
            #1 chkb(serial_out, t);
        end
    endtask
    task automatic t_events();
        // earlier scenarios leave sticky bits set, so start from a clean status
        wr(uisl_pkg::OFS_EVT_CLEAR, 8'h1F);
        wr(uisl_pkg::OFS_EVT_ENABLE, 8'h02);
        chkb(irq, 1'b0);
        setc(5'h02, 1'b0);
        @(posedge clk);
        #1 chkb(irq, 1'b1);
        rchk(uisl_pkg::OFS_EVT_STATUS, 8'h02);
        wr(uisl_pkg::OFS_EVT_CLEAR, 8'h02);
        chkb(irq, 1'b0);
        setc(5'h12, 1'b0);
        repeat (2) @(posedge clk);
        #1 chkb(irq, 1'b0);
        wr(uisl_pkg::OFS_EVT_STATUS, 8'h0F);
        rchk(uisl_pkg::OFS_EVT_STATUS, 8'h10);
        wr(uisl_pkg::OFS_EVT_ENABLE, 8'h10);
        chkb(irq, 1'b1);
        wr(uisl_pkg::OFS_EVT_CLEAR, 8'h1F);
        chkb(irq, 1'b0);
        rchk(uisl_pkg::OFS_EVT_CLEAR, 8'h00);
        rchk(3'h5, 8'h00);
        wr(uisl_pkg::OFS_INT_IDENT, 8'hFF);
        rchk(uisl_pkg::OFS_INT_IDENT, 8'h04);
        rchk(uisl_pkg::OFS_EVT_ENABLE, 8'h10);
        setc(5'h00, 1'b0);
    endtask
    task automatic conclude();
        if (err_count == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_codes();
        t_priority();
        t_format();
        t_break();
        t_events();
        conclude();
    end
endmodule // testbench
